// ---- jidt_params.svh ----
/*
 Constants of the boundary-scan test access block: instruction codes,
 widths and reset values. Assumes inclusion by bare name, once or more.
*/
// Notes on behaviour
// - Three-bit instruction shift register, copied to outputs only in update-IR.
// - Decode: 000 external test, 001 sample/preload, x1x bypass, 100 float, 101 clamp.
// - Test-logic-reset forces instruction outputs to all ones, meaning bypass.
// - Capture-IR loads the clamp code into the instruction shift register.
// - External test puts the 196-bit boundary register between TDI and TDO.
// - External test holds internal system logic in reset.
// - External test drives outputs, captures inputs, sets directions and enables.
// - Sample/preload presets boundary output cells before external test.
// - Live snapshot under sample is not supported; captured data is meaningless.
// - Bypass routes TDI through one-bit bypass register to TDO.
// - Bypass stage loads zero in capture-DR, so first bit out is zero.
// - Clamp selects bypass while pins are driven from boundary register data.
// - Float instruction turns off every output driver and selects bypass.
// - Three-state pin during system reset floats all outputs like float instruction.
// - Power-on reset holds controller in test-logic-reset, ignoring TMS.
// - Low-power stop allowed only in test-logic-reset; TCK never gated.
// - Five TMS-high rising TCK edges reach test-logic-reset.
// - TMS and TDI pulled up; open TMS keeps controller in test-logic-reset.
`ifndef JIDT_PARAMS_SVH
`define JIDT_PARAMS_SVH
`define JIDT_IR_W 3
`define JIDT_BSR_W 196
`define JIDT_IR_RESET 3'h7
`define JIDT_IR_CAPTURE 3'h5
`define JIDT_OP_EXTEST 3'h0
`define JIDT_OP_SAMPLE 3'h1
`define JIDT_OP_FLOAT 3'h4
`define JIDT_OP_CLAMP 3'h5
`define JIDT_FIFO_W 1
`define JIDT_FIFO_D 4
`endif

// ---- jidt_pkg.sv ----
/*
 Types of the boundary-scan test access block.
 Assumes the constants header is available for inclusion.
*/
package jidt_pkg;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } jidt_state_e;
    typedef enum logic [2:0] {
        OP_EXTEST, OP_SAMPLE, OP_BYPASS, OP_FLOAT, OP_CLAMP
    } jidt_op_e;
endpackage

// ---- jidt_fifo.sv ----
/*
 Small valid/ready FIFO with parameter width and depth.
 Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module jidt_fifo #(
    parameter int W = 1,
    parameter int D = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic push, pop;

    assign in_ready_o = (int'(cnt) < D);
    assign out_valid_o = (cnt != '0);
    assign out_data_o = mem[rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb
    begin
        next_wp = wp;
        next_rp = rp;
        next_cnt = cnt;
        if (push)
        begin
            next_wp = (int'(wp) == D - 1) ? '0 : wp + 1'b1;
        end
        if (pop)
        begin
            next_rp = (int'(rp) == D - 1) ? '0 : rp + 1'b1;
        end
        if (push && !pop)
        begin
            next_cnt = cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wp] <= in_data_i;
        end
    end
endmodule // jidt_fifo

// ---- jidt_tap.sv ----
/*
 Boundary-scan test access port: controller, instruction register and
 decode, bypass and 196-bit boundary register, pin drive control.
 Assumes TCK, TMS and TDI arrive asynchronously and are oversampled on
 clk_i; the 64 ns TCK leaves about six clk_i cycles per TCK half period.
 Pull-ups on TMS and TDI live in the pad ring; por_n_i is power-on reset.
*/
`timescale 1ns/1ps
`include "jidt_params.svh"
module jidt_tap
    import jidt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic por_n_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic three_state_all_pin_i,
    input wire logic system_reset_i,
    input wire logic low_power_stop_req_i,
    output logic low_power_stop_ok_o,
    output logic sys_reset_o,
    output logic pins_float_o,
    output logic pins_from_bsr_o,
    output logic [`JIDT_BSR_W-1:0] bsr_drive_o,
    input wire logic [`JIDT_BSR_W-1:0] pin_level_i
);
    // Two-stage synchronisers; first stage read only by the second
    logic [2:0] sync1, sync2;
    logic tck_d;
    logic tck_rise, tck_fall, tms_s, tdi_s;
    logic por_s1, por_s2, float_s1, float_s2;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1 <= 3'h6;
            sync2 <= 3'h6;
            tck_d <= 1'b0;
            por_s1 <= 1'b0;
            por_s2 <= 1'b0;
            float_s1 <= 1'b0;
            float_s2 <= 1'b0;
        end
        else
        begin
            sync1 <= {tms_i, tdi_i, tck_i};
            sync2 <= sync1;
            tck_d <= sync2[0];
            por_s1 <= por_n_i;
            por_s2 <= por_s1;
            float_s1 <= three_state_all_pin_i;
            float_s2 <= float_s1;
        end
    end

    assign tck_rise = sync2[0] && !tck_d;
    assign tck_fall = !sync2[0] && tck_d;
    assign tms_s = sync2[2];
    assign tdi_s = sync2[1];

    function automatic jidt_op_e decode_op(input logic [`JIDT_IR_W-1:0] code);
        jidt_op_e op;
        op = OP_BYPASS;
        if (code[1])
        begin
            op = OP_BYPASS;
        end
        else if (code == `JIDT_OP_EXTEST)
        begin
            op = OP_EXTEST;
        end
        else if (code == `JIDT_OP_SAMPLE)
        begin
            op = OP_SAMPLE;
        end
        else if (code == `JIDT_OP_FLOAT)
        begin
            op = OP_FLOAT;
        end
        else if (code == `JIDT_OP_CLAMP)
        begin
            op = OP_CLAMP;
        end
        return op;
    endfunction

    jidt_state_e state, next_state;
    logic [`JIDT_IR_W-1:0] ir_sh, next_ir_sh, ir, next_ir;
    logic byp, next_byp;
    logic [`JIDT_BSR_W-1:0] bsr_sh, next_bsr_sh, bsr_up, next_bsr_up;
    jidt_op_e op;
    logic bsr_sel;

    assign op = decode_op(ir);
    assign bsr_sel = (op == OP_EXTEST) || (op == OP_SAMPLE);

    always_comb
    begin
        next_state = state;
        next_ir_sh = ir_sh;
        next_ir = ir;
        next_byp = byp;
        next_bsr_sh = bsr_sh;
        next_bsr_up = bsr_up;
        if (!por_s2)
        begin
            next_state = TLR;
            next_ir = `JIDT_IR_RESET;
        end
        else if (tck_rise)
        begin
            case (state)
                TLR: next_state = tms_s ? TLR : RTI;
                RTI: next_state = tms_s ? SEL_DR : RTI;
                SEL_DR: next_state = tms_s ? SEL_IR : CAP_DR;
                CAP_DR: next_state = tms_s ? EX1_DR : SH_DR;
                SH_DR: next_state = tms_s ? EX1_DR : SH_DR;
                EX1_DR: next_state = tms_s ? UPD_DR : PAU_DR;
                PAU_DR: next_state = tms_s ? EX2_DR : PAU_DR;
                EX2_DR: next_state = tms_s ? UPD_DR : SH_DR;
                UPD_DR: next_state = tms_s ? SEL_DR : RTI;
                SEL_IR: next_state = tms_s ? TLR : CAP_IR;
                CAP_IR: next_state = tms_s ? EX1_IR : SH_IR;
                SH_IR: next_state = tms_s ? EX1_IR : SH_IR;
                EX1_IR: next_state = tms_s ? UPD_IR : PAU_IR;
                PAU_IR: next_state = tms_s ? EX2_IR : PAU_IR;
                EX2_IR: next_state = tms_s ? UPD_IR : SH_IR;
                UPD_IR: next_state = tms_s ? SEL_DR : RTI;
                default: next_state = TLR;
            endcase
            case (state)
                TLR: next_ir = `JIDT_IR_RESET;
                CAP_IR: next_ir_sh = `JIDT_IR_CAPTURE;
                SH_IR: next_ir_sh = {tdi_s, ir_sh[`JIDT_IR_W-1:1]};
                UPD_IR: next_ir = ir_sh;
                CAP_DR:
                begin
                    next_byp = 1'b0;
                    if (bsr_sel)
                    begin
                        // Sample snapshot unsupported; capture is pin levels only
                        next_bsr_sh = pin_level_i;
                    end
                end
                SH_DR:
                begin
                    if (bsr_sel)
                    begin
                        next_bsr_sh = {tdi_s, bsr_sh[`JIDT_BSR_W-1:1]};
                    end
                    else
                    begin
                        next_byp = tdi_s;
                    end
                end
                UPD_DR:
                begin
                    if (bsr_sel)
                    begin
                        next_bsr_up = bsr_sh;
                    end
                end
                default: next_ir_sh = ir_sh;
            endcase
        end
        else if (state == TLR)
        begin
            next_ir = `JIDT_IR_RESET;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= TLR;
            ir_sh <= `JIDT_IR_RESET;
            ir <= `JIDT_IR_RESET;
            byp <= 1'b0;
            bsr_sh <= '0;
            bsr_up <= '0;
        end
        else
        begin
            state <= next_state;
            ir_sh <= next_ir_sh;
            ir <= next_ir;
            byp <= next_byp;
            bsr_sh <= next_bsr_sh;
            bsr_up <= next_bsr_up;
        end
    end

    // Falling edge queues the current LSB; FIFO drains straight onto TDO
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [`JIDT_FIFO_W-1:0] fifo_in_data, fifo_out_data;
    logic shifting;

    assign shifting = (state == SH_IR) || (state == SH_DR);
    assign fifo_in_valid = tck_fall && shifting && por_s2 && fifo_in_ready;
    assign fifo_in_data = (state == SH_IR) ? ir_sh[0] : (bsr_sel ? bsr_sh[0] : byp);
    assign fifo_out_ready = 1'b1;

    jidt_fifo #(
        .W(`JIDT_FIFO_W),
        .D(`JIDT_FIFO_D)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // Output drive state; oe tracks the state as seen at the falling edge
    logic next_tdo, next_tdo_oe, next_sys_reset, next_float, next_from_bsr, next_lps;
    logic [`JIDT_BSR_W-1:0] next_drive;

    always_comb
    begin
        next_tdo = tdo_o;
        next_tdo_oe = tdo_oe_o;
        if (tck_fall)
        begin
            next_tdo_oe = shifting;
        end
        if (fifo_out_valid && fifo_out_ready)
        begin
            next_tdo = fifo_out_data[0];
        end
        if (!por_s2)
        begin
            next_tdo_oe = 1'b0;
        end
        next_sys_reset = (op == OP_EXTEST);
        next_float = (op == OP_FLOAT) || (float_s2 && system_reset_i);
        next_from_bsr = (op == OP_EXTEST) || (op == OP_CLAMP);
        next_drive = bsr_up;
        next_lps = low_power_stop_req_i && (state == TLR);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
            sys_reset_o <= 1'b0;
            pins_float_o <= 1'b0;
            pins_from_bsr_o <= 1'b0;
            bsr_drive_o <= '0;
            low_power_stop_ok_o <= 1'b0;
        end
        else
        begin
            tdo_o <= next_tdo;
            tdo_oe_o <= next_tdo_oe;
            sys_reset_o <= next_sys_reset;
            pins_float_o <= next_float;
            pins_from_bsr_o <= next_from_bsr;
            bsr_drive_o <= next_drive;
            low_power_stop_ok_o <= next_lps;
        end
    end
endmodule // jidt_tap

// ---- jidt_tap_props.sv ----
/*
 Port checker for the boundary-scan access block.
 Assumes TCK half periods of at least six clk_i cycles.
*/
`timescale 1ns/1ps
`include "jidt_params.svh"
module jidt_tap_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic por_n_i,
    input wire logic tck_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic three_state_all_pin_i,
    input wire logic system_reset_i,
    input wire logic low_power_stop_req_i,
    input wire logic low_power_stop_ok_o,
    input wire logic sys_reset_o,
    input wire logic pins_float_o,
    input wire logic pins_from_bsr_o,
    input wire logic [`JIDT_BSR_W-1:0] bsr_drive_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_por; !por_n_i [*4] |-> !tdo_oe_o && !sys_reset_o; endproperty
    a_por: assert property (p_por) else $error("tap active under power-on reset");
    property p_tdo_fall; $changed(tdo_o) |-> !tck_i; endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved while tck high");
    property p_oe_fall; $changed(tdo_oe_o) |-> !tck_i; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved while tck high");
    property p_lps_req; low_power_stop_ok_o |-> $past(low_power_stop_req_i); endproperty
    a_lps_req: assert property (p_lps_req) else $error("stop granted without request");
    property p_lps_tlr;
        low_power_stop_ok_o [*3] |-> !tdo_oe_o && !sys_reset_o && !pins_from_bsr_o;
    endproperty
    a_lps_tlr: assert property (p_lps_tlr) else $error("stop granted outside reset state");
    property p_float_pin;
        (three_state_all_pin_i && system_reset_i) [*4] |-> pins_float_o;
    endproperty
    a_float_pin: assert property (p_float_pin) else $error("float pin ignored");
    property p_float_excl;
        !three_state_all_pin_i [*4] |-> !(pins_float_o && pins_from_bsr_o);
    endproperty
    a_float_excl: assert property (p_float_excl) else $error("float and drive together");
    property p_sys_bsr; sys_reset_o |-> pins_from_bsr_o; endproperty
    a_sys_bsr: assert property (p_sys_bsr) else $error("external test without pin drive");
    property p_bsr_upd; $changed(bsr_drive_o) |-> tck_i; endproperty
    a_bsr_upd: assert property (p_bsr_upd) else $error("boundary latch moved off update");
endmodule // jidt_tap_props

bind jidt_tap jidt_tap_props u_jidt_tap_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .por_n_i(por_n_i), .tck_i(tck_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
    .three_state_all_pin_i(three_state_all_pin_i), .system_reset_i(system_reset_i),
    .low_power_stop_req_i(low_power_stop_req_i), .low_power_stop_ok_o(low_power_stop_ok_o),
    .sys_reset_o(sys_reset_o), .pins_float_o(pins_float_o),
    .pins_from_bsr_o(pins_from_bsr_o), .bsr_drive_o(bsr_drive_o));

// ---- jidt_tester.sv ----
/*
 Boundary-scan tester model: 64 ns TCK, stopped low between frames.
 Assumes pull-ups on TMS and TDI; TDO has none.
*/
`timescale 1ns/1ps
module jidt_tester (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    logic last = 1'b0;
    // Undriven TDO must not read as a stable level
    wire line = tdo_oe_i ? tdo_i : ~last;
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    always @(posedge tck_o) last <= line;
    task automatic tick(input logic ms, input logic di, output logic dout);
        tms_o = ms;
        tdi_o = di;
        #32;
        tck_o = 1'b1;
        dout = line;
        #32;
        tck_o = 1'b0;
    endtask
    task automatic scan(input logic ir, input int n, input logic [195:0] din,
            output logic [195:0] dout);
        logic d;
        dout = '0;
        // One low edge first, so a walk from test-logic-reset starts at idle
        tick(1'b0, 1'b1, d);
        tick(1'b1, 1'b1, d);
        if (ir) tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
        tick(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], d);
            dout[i] = d;
        end
        tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
        tms_o = 1'b1;
        tdi_o = 1'b1;
    endtask
endmodule // jidt_tester

// ---- jidt_tap_tb.sv ----
/*
 Self-checking bench of the boundary-scan access block.
 Assumes the tester model drives the scan pins asynchronously.
*/
`timescale 1ns/1ps
`include "jidt_params.svh"
module jidt_tap_tb;
    logic clk_i = 1'b0;
    logic rst_n_i, por, tck, tms, tdi, tdo, oe, tri3, srst, lreq, lok, hold, flt, fbsr;
    logic [195:0] drv, lvl, d, p, r;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    jidt_tap u_jidt_tap (.clk_i(clk_i), .rst_n_i(rst_n_i), .por_n_i(por), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(oe), .three_state_all_pin_i(tri3),
        .system_reset_i(srst), .low_power_stop_req_i(lreq), .low_power_stop_ok_o(lok),
        .sys_reset_o(hold), .pins_float_o(flt), .pins_from_bsr_o(fbsr),
        .bsr_drive_o(drv), .pin_level_i(lvl));
    jidt_tester u_jidt_tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
        .tdo_oe_i(oe));
    always #2.5 clk_i = ~clk_i;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            num_errors++;
            report_and_stop;
        end
    end
    task automatic chk(input string nm, input logic [195:0] e, input logic [195:0] s);
        tests_run++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic settle;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic t_start;
        logic b;
        lreq <= 1'b1;
        settle;
        chk("stop_ok", 1, lok);
        chk("sys_reset", 0, hold);
        por <= 1'b0;
        settle;
        // Walk towards shift-IR while power-on reset is held
        for (int i = 0; i < 5; i++) u_jidt_tester.tick(i == 1 || i == 2, 1'b1, b);
        settle;
        chk("stop_ok_por", 1, lok);
        por <= 1'b1;
        settle;
        chk("stop_ok_after", 1, lok);
        $display("t_start done");
    endtask
    task automatic t_codes;
        for (int c = 0; c < 8; c++)
        begin
            u_jidt_tester.scan(1'b1, 3, 196'(c), d);
            settle;
            chk("ir_capture", 3'h5, d[2:0]);
            chk("sys_reset", c == 0, hold);
            chk("from_bsr", c == 0 || c == 5, fbsr);
            chk("float", c == 4, flt);
            chk("stop_ok", 0, lok);
            chk("tdo_oe_idle", 0, oe);
            if (c > 1)
            begin
                u_jidt_tester.scan(1'b0, 2, 196'h3, d);
                chk("bypass", 2'h2, d[1:0]);
            end
        end
        $display("t_codes done");
    endtask
    task automatic t_bsr;
        p = {4{49'h1_5A5A_C3C3_F00F}};
        r = {p[97:0], p[195:98]};
        u_jidt_tester.scan(1'b1, 3, 196'h1, d);
        u_jidt_tester.scan(1'b0, 196, p, d);
        settle;
        chk("preload", p, drv);
        chk("from_bsr", 0, fbsr);
        // Pin levels move only while TCK is parked
        lvl <= ~p;
        u_jidt_tester.scan(1'b1, 3, 196'h0, d);
        settle;
        chk("from_bsr", 1, fbsr);
        u_jidt_tester.scan(1'b0, 196, r, d);
        settle;
        chk("capture", ~p, d);
        chk("drive", r, drv);
        u_jidt_tester.scan(1'b1, 3, 196'h5, d);
        settle;
        chk("clamp_drive", r, drv);
        chk("clamp_bsr", 1, fbsr);
        $display("t_bsr done");
    endtask
    task automatic t_float;
        tri3 <= 1'b1;
        settle;
        chk("float_no_reset", 0, flt);
        srst <= 1'b1;
        settle;
        chk("float_pin", 1, flt);
        tri3 <= 1'b0;
        srst <= 1'b0;
        settle;
        $display("t_float done");
    endtask
    task automatic t_tms5;
        logic b;
        u_jidt_tester.scan(1'b1, 3, 196'h0, d);
        // Park in shift-DR, then four TMS-high edges fall one short
        for (int i = 0; i < 7; i++) u_jidt_tester.tick(i == 0 || i > 2, 1'b1, b);
        settle;
        chk("four_high", 1, hold);
        u_jidt_tester.tick(1'b1, 1'b1, b);
        settle;
        chk("five_high", 0, hold);
        chk("five_high_ok", 1, lok);
        repeat (3) u_jidt_tester.tick(1'b1, 1'b1, b);
        settle;
        chk("stay_reset", 1, lok);
        $display("t_tms5 done");
    endtask
    initial
    begin
        rst_n_i = 1'b0;
        por = 1'b0;
        tri3 = 1'b0;
        srst = 1'b0;
        lreq = 1'b0;
        lvl = '0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        por <= 1'b1;
        settle;
        t_start;
        t_codes;
        t_bsr;
        t_float;
        t_tms5;
        report_and_stop;
    end
endmodule // jidt_tap_tb
